// File: logic/vdcf_regs.vh
`ifndef VDCF_REGS_VH
`define VDCF_REGS_VH
// register indices as printed; byte address is four times the index
`define VDCF_IDX_CLAMP_HI     8'h15
`define VDCF_IDX_CLAMP_LO     8'h16
`define VDCF_IDX_SHAPING      8'h17
`define VDCF_IDX_COMB         8'h19
`define VDCF_IDX_SC_HI        8'h23
`define VDCF_IDX_SC_MIDHI     8'h24
`define VDCF_IDX_SC_MIDLO     8'h25
`define VDCF_IDX_SC_LO        8'h26
// field positions
`define VDCF_CLAMP_FREEZE_BIT 4
`define VDCF_CLAMP_MODE_BIT   7
`define VDCF_SC_ENABLE_BIT    4
// reset values
`define VDCF_RST_CLAMP_HI     8'h00
`define VDCF_RST_CLAMP_LO     8'h00
`define VDCF_RST_SHAPING      8'h00
`define VDCF_RST_COMB         8'h00
`define VDCF_RST_SC_HI        8'hE0
`define VDCF_RST_SC           8'h00
// clamp time constants in milliseconds
`define VDCF_TC_SLOW_MS       1000
`define VDCF_TC_MED_MS        500
`define VDCF_TC_FAST_MS       100
// pclk rate in kHz
`define VDCF_CLK_KHZ          250000
`endif

// File: logic/vdcf_regs_apb.v
// Decided for this implementation: the APB register port.
`timescale 1ns/1ps
`include "vdcf_regs.vh"
module vdcf_regs_apb #(
    parameter SAMPLE_W = 12,
    parameter TC_SLOW  = (`VDCF_CLK_KHZ * `VDCF_TC_SLOW_MS),
    parameter TC_MED   = (`VDCF_CLK_KHZ * `VDCF_TC_MED_MS),
    parameter TC_FAST  = (`VDCF_CLK_KHZ * `VDCF_TC_FAST_MS)
) (
    input  wire                pclk,
    input  wire                presetn,
    input  wire                psel,
    input  wire                penable,
    input  wire                pwrite,
    input  wire [11:0]         paddr,
    input  wire [31:0]         pwdata,
    input  wire [3:0]          pstrb,
    output wire [31:0]         prdata,
    output wire                pready,
    output wire                pslverr,
    input  wire [SAMPLE_W-1:0] raw_sample,
    input  wire [SAMPLE_W-1:0] auto_offset,
    input  wire [1:0]          video_quality_setting,
    input  wire                scale_wide,
    output reg  [SAMPLE_W-1:0] chroma_sample,
    output reg                 clamp_freeze,
    output reg                 clamp_mode_select,
    output reg  [31:0]         clamp_tc_cycles,
    output reg                 clamp_tick,
    output reg  [3:0]          luma_filter_class,
    output reg  [4:0]          luma_filter_index,
    output reg  [2:0]          chroma_filter_index,
    output reg  [1:0]          comb_mode,
    output reg                 comb_adaptive_enable,
    output reg  [27:0]         subcarrier_freq,
    output reg                 manual_subcarrier_enable
);
    localparam LC_AUTO_WIDE   = 4'h0;
    localparam LC_AUTO_NARROW = 4'h1;
    localparam LC_SVIDEO      = 4'h2;
    localparam LC_PAL_NARROW  = 4'h3;
    localparam LC_PAL_WIDE    = 4'h4;
    localparam LC_NTSC_NARROW = 4'h5;
    localparam LC_NTSC_WIDE   = 4'h6;
    localparam LC_UNUSED      = 4'h7;

    localparam SLOT_CLAMP_HI  = 4'h0;
    localparam SLOT_CLAMP_LO  = 4'h1;
    localparam SLOT_SHAPING   = 4'h2;
    localparam SLOT_COMB      = 4'h3;
    localparam SLOT_SC_HI     = 4'h4;
    localparam SLOT_SC_MIDHI  = 4'h5;
    localparam SLOT_SC_MIDLO  = 4'h6;
    localparam SLOT_SC_LO     = 4'h7;
    localparam SLOT_NONE      = 4'h8;

    // one decode shared by the read mux and the write port
    function [3:0] slot_of;
        input [9:0] word_idx;
        begin
            case (word_idx)
                {2'b00, `VDCF_IDX_CLAMP_HI}: slot_of = SLOT_CLAMP_HI;
                {2'b00, `VDCF_IDX_CLAMP_LO}: slot_of = SLOT_CLAMP_LO;
                {2'b00, `VDCF_IDX_SHAPING}:  slot_of = SLOT_SHAPING;
                {2'b00, `VDCF_IDX_COMB}:     slot_of = SLOT_COMB;
                {2'b00, `VDCF_IDX_SC_HI}:    slot_of = SLOT_SC_HI;
                {2'b00, `VDCF_IDX_SC_MIDHI}: slot_of = SLOT_SC_MIDHI;
                {2'b00, `VDCF_IDX_SC_MIDLO}: slot_of = SLOT_SC_MIDLO;
                {2'b00, `VDCF_IDX_SC_LO}:    slot_of = SLOT_SC_LO;
                default:                     slot_of = SLOT_NONE;
            endcase
        end
    endfunction

    // sum wraps at the sample width; no saturation in this path
    function [SAMPLE_W-1:0] add_offset;
        input [SAMPLE_W-1:0] sample;
        input [SAMPLE_W-1:0] offset;
        begin
            add_offset = sample + offset;
        end
    endfunction

    reg  [7:0]  clamp_control_offset_high;
    reg  [7:0]  clamp_offset_low;
    reg  [7:0]  shaping_filter_control;
    reg  [7:0]  comb_filter_control;
    reg  [7:0]  subcarrier_control_high;
    reg  [7:0]  subcarrier_freq_mid_high;
    reg  [7:0]  subcarrier_freq_mid_low;
    reg  [7:0]  subcarrier_freq_low;
    reg  [31:0] rdata;
    reg  [31:0] prdata_q;
    reg  [3:0]  next_luma_class;
    reg  [4:0]  next_luma_index;
    reg  [31:0] tc_count;
    reg  [31:0] tc_target;

    wire [9:0]  idx    = paddr[11:2];
    wire [3:0]  slot   = slot_of(idx);
    wire        hit    = (slot != SLOT_NONE);
    wire        access = psel && penable;
    wire        wr_en  = access && pwrite && pstrb[0] && hit;

    wire [11:0] clamp_offset_value =
        {clamp_control_offset_high[3:0], clamp_offset_low};
    wire [1:0]  clamp_time_constant = clamp_control_offset_high[6:5];
    wire [4:0]  luma_shaping_select = shaping_filter_control[4:0];
    wire [2:0]  chroma_shaping_select = shaping_filter_control[7:5];

    assign pready  = 1'b1;
    assign pslverr = access && !hit;
    assign prdata  = prdata_q;

    // read mux; unmapped words read as zero
    always @* begin
        rdata = 32'h00000000;
        case (slot)
            SLOT_CLAMP_HI: rdata[7:0] = clamp_control_offset_high;
            SLOT_CLAMP_LO: rdata[7:0] = clamp_offset_low;
            SLOT_SHAPING:  rdata[7:0] = shaping_filter_control;
            SLOT_COMB:     rdata[7:0] = comb_filter_control;
            SLOT_SC_HI:    rdata[7:0] = subcarrier_control_high;
            SLOT_SC_MIDHI: rdata[7:0] = subcarrier_freq_mid_high;
            SLOT_SC_MIDLO: rdata[7:0] = subcarrier_freq_mid_low;
            SLOT_SC_LO:    rdata[7:0] = subcarrier_freq_low;
            default:       rdata[7:0] = 8'h00;
        endcase
    end

    // read word captured in the setup phase, so it stands from a
    // flip-flop through the whole zero-wait access phase
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h00000000;
        end else if (psel && !penable) begin
            prdata_q <= rdata;
        end
    end

    // registers store every bit written; reserved bits are software's
    // duty, so they are kept and read back as written
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clamp_control_offset_high <= `VDCF_RST_CLAMP_HI;
            clamp_offset_low          <= `VDCF_RST_CLAMP_LO;
            shaping_filter_control    <= `VDCF_RST_SHAPING;
            comb_filter_control       <= `VDCF_RST_COMB;
            subcarrier_control_high   <= `VDCF_RST_SC_HI;
            subcarrier_freq_mid_high  <= `VDCF_RST_SC;
            subcarrier_freq_mid_low   <= `VDCF_RST_SC;
            subcarrier_freq_low       <= `VDCF_RST_SC;
        end else if (wr_en) begin
            case (slot)
                SLOT_CLAMP_HI:
                    clamp_control_offset_high <= pwdata[7:0];
                SLOT_CLAMP_LO:
                    clamp_offset_low <= pwdata[7:0];
                SLOT_SHAPING:
                    shaping_filter_control <= pwdata[7:0];
                SLOT_COMB:
                    comb_filter_control <= pwdata[7:0];
                SLOT_SC_HI:
                    subcarrier_control_high <= pwdata[7:0];
                SLOT_SC_MIDHI:
                    subcarrier_freq_mid_high <= pwdata[7:0];
                SLOT_SC_MIDLO:
                    subcarrier_freq_mid_low <= pwdata[7:0];
                SLOT_SC_LO:
                    subcarrier_freq_low <= pwdata[7:0];
                default: ;
            endcase
        end
    end

    // time constant selection
    always @* begin
        case (clamp_time_constant)
            2'b00: tc_target = TC_SLOW;
            2'b01: tc_target = TC_MED;
            2'b10: tc_target = TC_FAST;
            // code 11 hands the choice to the core's quality input
            default: begin
                case (video_quality_setting)
                    2'b00:   tc_target = TC_SLOW;
                    2'b01:   tc_target = TC_MED;
                    default: tc_target = TC_FAST;
                endcase
            end
        endcase
    end

    // loop tick: one pulse per time constant, stopped while frozen
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tc_count   <= 32'h00000000;
            clamp_tick <= 1'b0;
        end else if (clamp_control_offset_high[`VDCF_CLAMP_FREEZE_BIT]) begin
            clamp_tick <= 1'b0;
        // a shorter constant landing below the count restarts it at once
        end else if (tc_count + 32'h00000001 >= tc_target) begin
            tc_count   <= 32'h00000000;
            clamp_tick <= 1'b1;
        end else begin
            tc_count   <= tc_count + 32'h00000001;
            clamp_tick <= 1'b0;
        end
    end

    // luma shaping decode, class plus index within class
    always @* begin
        next_luma_index = 5'h00;
        if (luma_shaping_select == 5'h00) begin
            next_luma_class = LC_AUTO_WIDE;
        end else if (luma_shaping_select == 5'h01) begin
            next_luma_class = LC_AUTO_NARROW;
        end else if (luma_shaping_select <= 5'h12) begin
            next_luma_class = LC_SVIDEO;
            next_luma_index = luma_shaping_select - 5'h01;
        end else if (luma_shaping_select <= 5'h15) begin
            next_luma_class = LC_PAL_NARROW;
            next_luma_index = luma_shaping_select - 5'h12;
        end else if (luma_shaping_select <= 5'h17) begin
            next_luma_class = LC_PAL_WIDE;
            next_luma_index = luma_shaping_select - 5'h15;
        end else if (luma_shaping_select <= 5'h1A) begin
            next_luma_class = LC_NTSC_NARROW;
            next_luma_index = luma_shaping_select - 5'h17;
        end else if (luma_shaping_select <= 5'h1D) begin
            next_luma_class = LC_NTSC_WIDE;
            next_luma_index = luma_shaping_select - 5'h1A;
        end else if (luma_shaping_select == 5'h1E) begin
            next_luma_class = LC_UNUSED;
        end else begin
            next_luma_class = LC_SVIDEO;
            next_luma_index = 5'h12;
        end
    end

    // registered so the core never sees a decode glitch mid-write
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            luma_filter_class <= LC_AUTO_WIDE;
            luma_filter_index <= 5'h00;
        end else begin
            luma_filter_class <= next_luma_class;
            luma_filter_index <= next_luma_index;
        end
    end

    // core-facing outputs, all registered
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chroma_sample            <= {SAMPLE_W{1'b0}};
            clamp_freeze             <= 1'b0;
            clamp_mode_select        <= 1'b0;
            clamp_tc_cycles          <= 32'h00000000;
            chroma_filter_index      <= 3'h0;
            comb_mode                <= 2'h0;
            comb_adaptive_enable     <= 1'b0;
            subcarrier_freq          <= 28'h0000000;
            manual_subcarrier_enable <= 1'b0;
        end else begin
            clamp_freeze <=
                clamp_control_offset_high[`VDCF_CLAMP_FREEZE_BIT];
            clamp_mode_select <=
                clamp_control_offset_high[`VDCF_CLAMP_MODE_BIT];
            clamp_tc_cycles <= tc_target;
            // manual offset corrects the chroma path only
            if (clamp_control_offset_high[`VDCF_CLAMP_MODE_BIT])
                chroma_sample <=
                    add_offset(raw_sample, clamp_offset_value);
            else
                chroma_sample <=
                    add_offset(raw_sample, auto_offset);
            // auto setting 0 picks by scaling: wide scaling gets 2nd choice; setting 1 always gets it
            if (chroma_shaping_select[2:1] == 2'b00)
                chroma_filter_index <= {2'b00,
                    chroma_shaping_select[0] | scale_wide};
            else
                chroma_filter_index <= chroma_shaping_select - 3'h1;
            comb_mode            <= comb_filter_control[3:2];
            comb_adaptive_enable <= comb_filter_control[4];
            subcarrier_freq <= {subcarrier_control_high[3:0],
                subcarrier_freq_mid_high, subcarrier_freq_mid_low,
                subcarrier_freq_low};
            manual_subcarrier_enable <=
                subcarrier_control_high[`VDCF_SC_ENABLE_BIT];
        end
    end
endmodule

// File: verif/vdcf_checker.sv
`timescale 1ns/1ps
`include "vdcf_regs.vh"
module vdcf_checker #(
    parameter SAMPLE_W = 12
) (
    input wire                pclk,
    input wire                presetn,
    input wire                psel,
    input wire                penable,
    input wire                pwrite,
    input wire [11:0]         paddr,
    input wire [31:0]         pwdata,
    input wire [3:0]          pstrb,
    input wire [31:0]         prdata,
    input wire                pready,
    input wire                pslverr,
    input wire [SAMPLE_W-1:0] raw_sample,
    input wire [SAMPLE_W-1:0] auto_offset,
    input wire [SAMPLE_W-1:0] chroma_sample,
    input wire                clamp_freeze,
    input wire                clamp_mode_select,
    input wire                clamp_tick,
    input wire                manual_subcarrier_enable
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence wr_at(logic [7:0] ix);
        psel && penable && pwrite && pstrb[0] && paddr == {2'b00, ix, 2'b00};
    endsequence
    ready_in_access_a: assert property (psel && penable |-> pready)
        else $error("pready low in access phase");
    err_in_access_a: assert property (pslverr |-> psel && penable)
        else $error("pslverr outside access phase");
    rdata_upper_a: assert property (psel && penable && !pwrite
        |-> prdata[31:8] == 24'h000000) else $error("prdata upper bits set");
    unmapped_read_a: assert property (psel && penable && pslverr
        |-> prdata == 32'h00000000) else $error("unmapped read not zero");
    clamp_bits_a: assert property (wr_at(`VDCF_IDX_CLAMP_HI) |=>
        ##1 clamp_freeze == $past(pwdata[4], 2)
        && clamp_mode_select == $past(pwdata[7], 2))
        else $error("clamp control bits not applied");
    sc_enable_a: assert property (wr_at(`VDCF_IDX_SC_HI) |=> ##1
        manual_subcarrier_enable == $past(pwdata[4], 2))
        else $error("subcarrier enable not applied");
    auto_offset_a: assert property (
        $past(presetn) && !clamp_mode_select
        |-> chroma_sample == $past(SAMPLE_W'(raw_sample + auto_offset)))
        else $error("automatic offset not applied");
    frozen_no_tick_a: assert property (
        clamp_freeze && $past(clamp_freeze) |-> !clamp_tick)
        else $error("clamp tick while frozen");
endmodule
bind vdcf_regs_apb vdcf_checker #(.SAMPLE_W(SAMPLE_W)) u_chk (.*);

// File: verif/testbench.sv
`timescale 1ns/1ps
`include "vdcf_regs.vh"
module testbench;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic        scale_wide, clamp_freeze, clamp_mode_select, clamp_tick;
    logic        comb_adaptive_enable, manual_subcarrier_enable;
    logic [11:0] paddr, raw_sample, auto_offset, chroma_sample;
    logic [31:0] pwdata, prdata, clamp_tc_cycles;
    logic [3:0]  pstrb, luma_filter_class;
    logic [4:0]  luma_filter_index;
    logic [2:0]  chroma_filter_index;
    logic [1:0]  video_quality_setting, comb_mode;
    logic [27:0] subcarrier_freq;
    logic [7:0]  rd;
    int          errors, n_compared, cyc, i, k, n;
    int          tcs [3] = '{20, 10, 5};
    logic [7:0]  idx [8] = '{`VDCF_IDX_CLAMP_HI, `VDCF_IDX_CLAMP_LO,
        `VDCF_IDX_SHAPING, `VDCF_IDX_COMB, `VDCF_IDX_SC_HI,
        `VDCF_IDX_SC_MIDHI, `VDCF_IDX_SC_MIDLO, `VDCF_IDX_SC_LO};
    logic [7:0]  rst [8] = '{`VDCF_RST_CLAMP_HI, `VDCF_RST_CLAMP_LO,
        `VDCF_RST_SHAPING, `VDCF_RST_COMB, `VDCF_RST_SC_HI,
        `VDCF_RST_SC, `VDCF_RST_SC, `VDCF_RST_SC};
    logic [7:0]  wv [8] = '{8'hA5, 8'h3C, 8'h5A, 8'h14,
        8'hF9, 8'h81, 8'h42, 8'h7E};
    // short time constants keep the tick test brief
    vdcf_regs_apb #(.TC_SLOW(20), .TC_MED(10), .TC_FAST(5)) u_dut (.*);
    initial begin
        pclk = 0;
        forever #2 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            errors++;
            tally_and_finish;
        end
    end
    task tally_and_finish;
        if (errors == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task check(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            errors++;
            $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
        end
    endtask
    // request held until pready is seen at an edge, then released
    task xfer(input logic w, input logic [7:0] ix, d, input logic s);
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= {2'b00, ix, 2'b00};
        pwdata <= {24'h000000, d};
        pstrb <= {3'b000, s && w};
        @(posedge pclk);
        penable <= 1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata[7:0];
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task settle;
        repeat (2) @(posedge pclk);
        #1;
    endtask
    function automatic logic [8:0] luma_exp(input int c);
        if (c < 2) return {4'(c), 5'h00};
        if (c < 19 || c == 31) return {4'h2, (c == 31) ? 5'h12 : 5'(c - 1)};
        if (c < 22) return {4'h3, 5'(c - 18)};
        if (c < 24) return {4'h4, 5'(c - 21)};
        if (c < 27) return {4'h5, 5'(c - 23)};
        if (c < 30) return {4'h6, 5'(c - 26)};
        return {4'h7, 5'h00};
    endfunction
    initial begin
        {presetn, psel, penable, pwrite, scale_wide} = 5'h00;
        {paddr, pwdata, pstrb} = 48'h0;
        raw_sample = 12'h100;
        auto_offset = 12'h010;
        video_quality_setting = 2'h0;
        {errors, n_compared, cyc} = 96'h0;
        repeat (12) @(posedge pclk);
        presetn <= 1;
        for (i = 0; i < 8; i++) begin
            xfer(0, idx[i], 8'h00, 1);
            check("reset value", rst[i], rd);
        end
        for (i = 0; i < 8; i++) xfer(1, idx[i], wv[i], 1);
        for (i = 0; i < 8; i++) begin
            xfer(0, idx[i], 8'h00, 1);
            check("readback", wv[i], rd);
        end
        settle;
        check("manual offset", 12'h63C, chroma_sample);
        check("sc word", 28'h981427E, subcarrier_freq);
        check("sc enable", 1, manual_subcarrier_enable);
        check("comb", 3'h5, {comb_adaptive_enable, comb_mode});
        xfer(1, 8'h18, 8'hFF, 1);
        check("unmapped err", 1, err);
        xfer(0, 8'h18, 8'h00, 1);
        check("unmapped read", {1'b1, 8'h00}, {err, rd});
        xfer(1, `VDCF_IDX_CLAMP_LO, 8'hFF, 0);
        xfer(0, `VDCF_IDX_CLAMP_LO, 8'h00, 1);
        check("strobe off", 8'h3C, rd);
        for (k = 0; k < 32; k++) begin
            @(posedge pclk);
            scale_wide <= k[3];
            xfer(1, `VDCF_IDX_SHAPING, {k[2:0], k[4:0]}, 1);
            settle;
            check("luma", luma_exp(k),
                {luma_filter_class, luma_filter_index});
            n = (k % 8 == 0) ? k[3] : (k % 8 == 1) ? 1 : k % 8 - 1;
            check("chroma", n, chroma_filter_index);
        end
        for (k = 0; k < 6; k++) begin
            xfer(1, `VDCF_IDX_COMB,
                {3'h0, k > 2, 2'(k % 3), 2'h0}, 1);
            settle;
            check("comb", {k > 2, 2'(k % 3)},
                {comb_adaptive_enable, comb_mode});
        end
        for (k = 0; k < 16; k++) begin
            @(posedge pclk);
            video_quality_setting <= k[1:0];
            xfer(1, `VDCF_IDX_CLAMP_HI, {1'b0, k[3:2], 5'h00}, 1);
            settle;
            n = (k[3:2] == 3) ? ((k[1:0] > 2) ? 2 : k[1:0]) : k[3:2];
            check("tc", tcs[n], clamp_tc_cycles);
        end
        check("auto offset", 12'h110, chroma_sample);
        for (k = 0; k < 2; k++) begin
            xfer(1, `VDCF_IDX_CLAMP_HI, {3'h2, k[0], 4'h0}, 1);
            settle;
            n = 0;
            repeat (40) begin
                @(posedge pclk);
                if (clamp_tick === 1'b1) n++;
            end
            check("ticks", 1,
                k ? n == 0 : n >= 7 && n <= 9);
        end
        xfer(1, `VDCF_IDX_SC_HI, 8'hE9, 1);
        settle;
        check("sc off", 0, manual_subcarrier_enable);
        tally_and_finish;
    end
endmodule
